/* File: scratch_handshake_pkg.sv */
/*
 * Constants for the dual-port scratch and handshake mailbox.
 * Assumes both register ports are synchronous to I_MCLK.
 */
`default_nettype none
package scratch_handshake_pkg;
    localparam logic [2:0] MODEM_CR1_ADDR = 3'h1;
    localparam logic [2:0] MODEM_CR2_ADDR = 3'h2;
    localparam logic [2:0] MODEM_SCRATCH_ADDR = 3'h6;
    localparam logic [2:0] MODEM_HANDSHAKE_ADDR = 3'h7;
    localparam logic [3:0] HOST_SCRATCH_ADDR = 4'he;
    localparam logic [3:0] HOST_HANDSHAKE_ADDR = 4'hf;
    localparam logic [7:0] SCRATCH_RESET = 8'h00;
    localparam logic [3:0] STATUS_RESET = 4'h0;
    localparam logic [1:0] PATTERN_RESET = 2'h0;
    localparam int STATUS_LSB = 0;
    localparam int DTR_BIT = 4;
    localparam int RTS_BIT = 5;
    localparam int UART_TX_BIT_CLOCK_BIT = 7;
    localparam int PATTERN_LSB = 6;
    localparam logic [1:0] PAT_DATA = 2'h0;
    localparam logic [1:0] PAT_ALT = 2'h1;
    localparam logic [1:0] PAT_MARK = 2'h2;
    localparam logic [1:0] PAT_SPACE = 2'h3;
endpackage
`default_nettype wire

/* File: scratch_handshake.sv */
/*
 * Dual-port scratch register and handshake mirror between the modem
 * microprocessor port and the host UART port, plus the transmit pattern
 * generator timed to the UART bit clock.
 * Assumes all inputs are synchronous to I_MCLK; the UART core supplies
 * its bit clock, DTR/RTS bits and serial data as plain levels.
 */
`default_nettype none
module scratch_handshake (
    input wire logic I_MCLK,
    input wire logic I_RESET_N,
    input wire logic I_PORT_MODE_STRAP,
    input wire logic [2:0] I_MODEM_PORT_ADDR,
    input wire logic I_MODEM_WR,
    input wire logic [7:0] I_MODEM_WDATA,
    output logic [7:0] O_MODEM_RDATA,
    input wire logic [3:0] I_HOST_PORT_ADDR,
    input wire logic I_HOST_WR,
    input wire logic [7:0] I_HOST_WDATA,
    output logic [7:0] O_HOST_RDATA,
    input wire logic [3:0] I_STATUS_PINS,
    output logic [3:0] O_HOST_LINE_STATUS,
    input wire logic I_HOST_DTR,
    input wire logic I_HOST_RTS,
    input wire logic I_UART_TX_BIT_CLOCK,
    input wire logic I_UART_TXD,
    output logic O_SERIAL_TXD
);
    import scratch_handshake_pkg::*;

    typedef struct packed {
        logic [7:0] scratch;
        logic [3:0] status;
        logic [1:0] pattern;
        logic clk_prev;
        logic alt;
        logic txd;
    } state_t;

    state_t q, d;
    logic [7:0] handshake_mirror_reg;
    logic clk_fall;
    logic next_bit;

    // Composite handshake view shared by both ports
    always_comb begin
        handshake_mirror_reg = 8'h00;
        handshake_mirror_reg[STATUS_LSB +: 4] = q.status;
        handshake_mirror_reg[DTR_BIT] = I_HOST_DTR;
        handshake_mirror_reg[RTS_BIT] = I_HOST_RTS;
        handshake_mirror_reg[UART_TX_BIT_CLOCK_BIT] = I_UART_TX_BIT_CLOCK;
    end

    // Falling edge of the UART bit clock, seen one system clock late.
    // The edge register resets low, so the release of reset never fakes a fall
    // while the bit clock idles high.
    assign clk_fall = q.clk_prev & ~I_UART_TX_BIT_CLOCK;

    // Pattern selection; alternating toggles once per bit
    always_comb begin
        unique case (q.pattern)
            PAT_DATA: next_bit = I_UART_TXD;
            PAT_ALT: next_bit = ~q.alt;
            PAT_MARK: next_bit = 1'b1;
            PAT_SPACE: next_bit = 1'b0;
        endcase
    end

    // Next state; modem write applied last so it wins a scratch collision
    always_comb begin
        d = q;
        d.clk_prev = I_UART_TX_BIT_CLOCK;
        if (I_HOST_WR && I_HOST_PORT_ADDR == HOST_SCRATCH_ADDR) begin
            d.scratch = I_HOST_WDATA;
        end
        if (I_MODEM_WR) begin
            unique case (I_MODEM_PORT_ADDR)
                MODEM_SCRATCH_ADDR: d.scratch = I_MODEM_WDATA;
                MODEM_HANDSHAKE_ADDR: d.status = I_MODEM_WDATA[STATUS_LSB +: 4];
                MODEM_CR1_ADDR: d.pattern = I_MODEM_WDATA[PATTERN_LSB +: 2];
                MODEM_CR2_ADDR: d = d;
                default: d = d;
            endcase
        end
        // Serial output only moves on the falling bit clock edge
        if (clk_fall) begin
            d.txd = next_bit;
            d.alt = next_bit;
        end
    end

    // State register; alt starts equal to txd so the first alternating bit really toggles
    // and the output idles at mark until the first falling bit clock edge.
    always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            q <= '{scratch: SCRATCH_RESET, status: STATUS_RESET, pattern: PATTERN_RESET,
                   clk_prev: 1'b0, alt: 1'b1, txd: 1'b1};
        end else begin
            q <= d;
        end
    end

    // Strap high means dual-port: mailbox bits feed the host status
    assign O_HOST_LINE_STATUS = I_PORT_MODE_STRAP ? q.status : I_STATUS_PINS;
    assign O_SERIAL_TXD = q.txd;

    // Combinational read mux; only the mapped addresses return data
    always_comb begin
        O_MODEM_RDATA = 8'h00;
        if (I_MODEM_PORT_ADDR == MODEM_SCRATCH_ADDR) O_MODEM_RDATA = q.scratch;
        if (I_MODEM_PORT_ADDR == MODEM_HANDSHAKE_ADDR) O_MODEM_RDATA = handshake_mirror_reg;
        if (I_MODEM_PORT_ADDR == MODEM_CR1_ADDR) O_MODEM_RDATA = {q.pattern, 6'h00};
        O_HOST_RDATA = 8'h00;
        if (I_HOST_PORT_ADDR == HOST_SCRATCH_ADDR) O_HOST_RDATA = q.scratch;
        if (I_HOST_PORT_ADDR == HOST_HANDSHAKE_ADDR) O_HOST_RDATA = handshake_mirror_reg;
    end

    // Checks on the register ports and the serial pattern path.
    // Each property on a write or a bit clock edge looks at what the block drives one clock after the
    // event that should cause it, so a broken decode or a lost write shows.
    // Reads are combinational, so read-side checks compare in the same cycle.
    // The bit clock is taken as a level; its edges are found by clk_fall only.
    // Limitation: a bit clock faster than half the system clock would be missed.
    scratch_prio_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        (I_MODEM_WR && I_MODEM_PORT_ADDR == MODEM_SCRATCH_ADDR) |=> q.scratch == $past(I_MODEM_WDATA))
        else $error("modem scratch write lost");
    host_scratch_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        (I_HOST_WR && I_HOST_PORT_ADDR == HOST_SCRATCH_ADDR && !(I_MODEM_WR && I_MODEM_PORT_ADDR == MODEM_SCRATCH_ADDR))
        |=> O_HOST_RDATA == $past(I_HOST_WDATA) || I_HOST_PORT_ADDR != HOST_SCRATCH_ADDR)
        else $error("host scratch write lost");
    status_dual_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        (I_MODEM_WR && I_MODEM_PORT_ADDR == MODEM_HANDSHAKE_ADDR) ##1 I_PORT_MODE_STRAP
        |-> O_HOST_LINE_STATUS == $past(I_MODEM_WDATA[3:0]))
        else $error("dual-port status mismatch");
    status_single_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        !I_PORT_MODE_STRAP |-> O_HOST_LINE_STATUS == I_STATUS_PINS)
        else $error("single-port status mismatch");
    mirror_bits_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        (I_MODEM_PORT_ADDR == MODEM_HANDSHAKE_ADDR) |-> O_MODEM_RDATA[5:4] == {I_HOST_RTS, I_HOST_DTR})
        else $error("DTR/RTS mirror wrong");
    uart_tx_bit_clock_bit_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        (I_HOST_PORT_ADDR == HOST_HANDSHAKE_ADDR) |-> O_HOST_RDATA[7] == I_UART_TX_BIT_CLOCK)
        else $error("bit clock not mirrored");
    txd_edge_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        !$stable(O_SERIAL_TXD) |-> $past(clk_fall))
        else $error("serial data moved off falling edge");
    pattern_mark_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        (clk_fall && q.pattern == PAT_MARK) |=> O_SERIAL_TXD)
        else $error("mark pattern not sent");
    bit6_zero_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        (I_MODEM_PORT_ADDR == MODEM_HANDSHAKE_ADDR) |-> !O_MODEM_RDATA[6])
        else $error("handshake bit 6 not zero");

    // Reserved control register must not disturb the pattern or status field
    cr2_ignored_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        (I_MODEM_WR && I_MODEM_PORT_ADDR == MODEM_CR2_ADDR)
        |=> q.pattern == $past(q.pattern) && q.status == $past(q.status))
        else $error("reserved register write took effect");

    // Host side may only read the handshake register
    host_hs_ro_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        (I_HOST_WR && I_HOST_PORT_ADDR == HOST_HANDSHAKE_ADDR && !I_MODEM_WR)
        |=> q.status == $past(q.status))
        else $error("host wrote handshake status");

    // Modem scratch write is visible on the host port next cycle
    scratch_both_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        (I_MODEM_WR && I_MODEM_PORT_ADDR == MODEM_SCRATCH_ADDR)
        |=> (I_HOST_PORT_ADDR != HOST_SCRATCH_ADDR || O_HOST_RDATA == $past(I_MODEM_WDATA)))
        else $error("scratch not shared with host");

    // Pattern field reads back as written
    cr1_read_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        (I_MODEM_WR && I_MODEM_PORT_ADDR == MODEM_CR1_ADDR)
        |=> (I_MODEM_PORT_ADDR != MODEM_CR1_ADDR || O_MODEM_RDATA[7:6] == $past(I_MODEM_WDATA[7:6])))
        else $error("pattern field readback wrong");

    // Host view of the DTR and RTS copies
    host_mirror_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        (I_HOST_PORT_ADDR == HOST_HANDSHAKE_ADDR)
        |-> O_HOST_RDATA[5:4] == {I_HOST_RTS, I_HOST_DTR})
        else $error("host DTR/RTS mirror wrong");

    // Modem view of the bit clock
    modem_uart_tx_bit_clock_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        (I_MODEM_PORT_ADDR == MODEM_HANDSHAKE_ADDR)
        |-> O_MODEM_RDATA[7] == I_UART_TX_BIT_CLOCK)
        else $error("modem bit clock not mirrored");

    // Unused bit also reads zero on the host side
    host_bit6_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        (I_HOST_PORT_ADDR == HOST_HANDSHAKE_ADDR)
        |-> !O_HOST_RDATA[6])
        else $error("host handshake bit 6 not zero");

    // Output holds between falling bit clock edges
    txd_hold_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        !clk_fall
        |=> $stable(O_SERIAL_TXD))
        else $error("serial data moved without edge");

    // Constant space pattern
    pattern_space_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        (clk_fall && q.pattern == PAT_SPACE)
        |=> !O_SERIAL_TXD)
        else $error("space pattern not sent");

    // Alternating pattern flips at every falling bit clock edge
    pattern_alt_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        (clk_fall && q.pattern == PAT_ALT)
        |=> O_SERIAL_TXD != $past(O_SERIAL_TXD))
        else $error("alternating pattern did not flip");

    // Normal mode passes the UART data taken at the edge
    pattern_data_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        (clk_fall && q.pattern == PAT_DATA)
        |=> O_SERIAL_TXD == $past(I_UART_TXD))
        else $error("normal data not passed");
endmodule
`default_nettype wire

/* File: uart_side_model.sv */
/* Stand-in for the UART core: bit clock and serial data.
   Assumes the bench clock and an active-low reset. */
`default_nettype none
module uart_side_model (
    input wire logic i_clk,
    input wire logic i_rst_n,
    output logic o_bclk,
    output logic o_txd
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] cnt;
    logic [7:0] sh;
    assign o_txd = sh[0];
    // Half period of five clocks; a shift register stands in for real data
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt <= 3'h0;
            o_bclk <= 1'b1;
            sh <= 8'h96;
        end else if (cnt == 3'h4) begin
            cnt <= 3'h0;
            o_bclk <= #1 ~o_bclk;
            // Data moves with the falling bit clock only
            if (o_bclk) sh <= #1 {sh[6:0], sh[7] ^ sh[5]};
        end else cnt <= cnt + 3'h1;
    end
endmodule
`default_nettype wire

/* File: dual_port_scratch_handshake_tb.sv */
/* Self-checking bench for the scratch and handshake block.
   Assumes the UART stand-in drives bit clock and serial data. */
`default_nettype none
module dual_port_scratch_handshake_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, strap, mwr, hwr, dtr, rts, bclk, utxd, stxd, mon_on, tprev;
    logic [2:0] maddr;
    logic [3:0] haddr, pins, hstat, h;
    logic [7:0] mwd, mrd, hwd, hrd;
    logic [1:0] pat;
    int n_mismatch = 0, check_count = 0;
    scratch_handshake uut (.I_MCLK(clk), .I_RESET_N(rst_n), .I_PORT_MODE_STRAP(strap),
        .I_MODEM_PORT_ADDR(maddr), .I_MODEM_WR(mwr), .I_MODEM_WDATA(mwd), .O_MODEM_RDATA(mrd),
        .I_HOST_PORT_ADDR(haddr), .I_HOST_WR(hwr), .I_HOST_WDATA(hwd), .O_HOST_RDATA(hrd),
        .I_STATUS_PINS(pins), .O_HOST_LINE_STATUS(hstat), .I_HOST_DTR(dtr), .I_HOST_RTS(rts),
        .I_UART_TX_BIT_CLOCK(bclk), .I_UART_TXD(utxd), .O_SERIAL_TXD(stxd));
    uart_side_model far (.i_clk(clk), .i_rst_n(rst_n), .o_bclk(bclk), .o_txd(utxd));
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic summarize();
        if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // One write on either port; strobes drop a cycle later so back-to-back calls are clean
    task automatic wr(input logic m, input logic [3:0] a, input logic [7:0] d);
        {maddr, haddr, mwd, hwd} = {a[2:0], a, d, d};
        if (m) mwr = 1;
        else hwr = 1;
        @(posedge clk);
        #1 {mwr, hwr} = 2'b00;
    endtask
    // Reads are combinational; bit 7 of the handshake follows the live bit clock
    task automatic rd(input logic m, input logic [3:0] a, input logic [7:0] e);
        {maddr, haddr} = {a[2:0], a};
        #5 if (m && a == 4'h7) e[7] = bclk;
        chk(m ? "modem_rdata" : "host_rdata", e, m ? mrd : hrd);
        @(posedge clk);
        #1;
    endtask
    // Watch serial output at mid-cycle, against bit clock history
    always @(negedge clk) begin
        h = {h[2:0], bclk};
        if (mon_on && stxd !== tprev) chk("txd_edge", 8'h1, {7'h0, h[2] & ~h[1]});
        if (mon_on && pat == 2'h1) chk("txd_alt", {7'h0, h[2] & ~h[1]}, {7'h0, stxd !== tprev});
        if (mon_on && pat[1]) chk("txd_fixed", {7'h0, ~pat[0]}, {7'h0, stxd});
        if (mon_on && pat == 2'h0 && &h) chk("txd_data", {7'h0, utxd}, {7'h0, stxd});
        tprev = stxd;
    end
    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    // Run limit well past the whole sequence
    initial begin
        #200000 n_mismatch++;
        summarize();
    end
    initial begin
        {rst_n, strap, mwr, hwr, dtr, rts, mon_on, maddr, haddr, pins, mwd, hwd, pat, h} = 0;
        strap = 1;
        repeat (6) @(posedge clk);
        #1 rst_n = 1;
        rd(1, 4'h6, 8'h00);
        wr(1, 4'h6, 8'h5a);
        rd(0, 4'he, 8'h5a);
        wr(0, 4'he, 8'ha5);
        rd(1, 4'h6, 8'ha5);
        {maddr, mwd, haddr, hwd, mwr, hwr} = {3'h6, 8'h11, 4'he, 8'h22, 2'b11};
        @(posedge clk);
        #1 {mwr, hwr} = 2'b00;
        rd(0, 4'he, 8'h11);
        dtr = 1;
        wr(1, 4'h7, 8'hff);
        rd(1, 4'h7, 8'h1f);
        chk("line_status", 8'h0f, {4'h0, hstat});
        {dtr, rts} = 2'b01;
        wr(1, 4'h7, 8'h40);
        rd(1, 4'h7, 8'h20);
        {strap, pins} = 5'h05;
        rd(1, 4'h2, 8'h00);
        chk("line_status", 8'h05, {4'h0, hstat});
        wr(1, 4'h2, 8'hff);
        rd(1, 4'h2, 8'h00);
        rd(1, 4'h1, 8'h00);
        for (int p = 0; p < 4; p++) begin
            mon_on = 0;
            pat = 2'(p);
            @(negedge bclk);
            wr(1, 4'h1, {pat, 6'h00});
            rd(1, 4'h1, {pat, 6'h00});
            repeat (40) @(posedge clk);
            mon_on = 1;
            repeat (80) @(posedge clk);
        end
        summarize();
    end
endmodule
`default_nettype wire
